// ---- logic/plh_pkg.sv ----
// shared constants, types and register map of the palette look-up block
//
// Contract
// - host accesses are taken on the pixel clock; the block itself leaves idle gaps between them
// - during a host RAM transfer the outputs keep showing the previous colour
// - two-bit phase, readable in status bits 1..0, counts modulo three: red, green, blue
// - writing the pointer clears the phase; reading it does not
// - the eight-bit pointer advances after every blue-phase access
// - reading the pointer changes neither pointer, phase nor read/write mode
// - select 001 reaches the colour RAM, 101 reaches overlays 1 to 15
// - depth is eight-bit when the depth pin or depth_select_bit is set
// - six-bit depth uses data lines 5..0; lines 7..6 ignored, read as zero
// - six-bit depth forces the two converter LSBs to zero
// - eight-bit depth moves each colour byte on all eight lines
// - pixel index is ANDed with the pixel mask before look-up
// - overlay select zero uses colour RAM, nonzero outputs that overlay entry
// - each entry gives 18 bits in six-bit depth, 24 bits in eight-bit depth
// - sync and blank are latched on the rising edge, aligned with colour
// - powerdown_bit set turns off look-up RAM and converters
// - while powered down the RAM keeps data and wakes for each colour/overlay data access and read-pointer write
// - monitor-detect goes low when any output exceeds the comparator threshold
// - blank low outputs blank level; sync low removes pedestal on enabled channels
// - sync_channel_enables choose which channels carry the sync pedestal
// - overlay accesses ignore pointer bits 7..4; the pointer wraps from ff to 00
// - writes commit after blue; read mode prefetches on pointer load or advance
package plh_pkg;
	// ****************************************
	// register map, word select codes decoded from address bits 4..2
	// ****************************************
	localparam logic [2:0] RS_PTR_WR  = 3'h0;
	localparam logic [2:0] RS_COLOUR  = 3'h1;
	localparam logic [2:0] RS_MASK    = 3'h2;
	localparam logic [2:0] RS_PTR_RD  = 3'h3;
	localparam logic [2:0] RS_OVERLAY = 3'h5;
	localparam logic [2:0] RS_CTRL    = 3'h6;
	localparam logic [2:0] RS_STATUS  = 3'h7;
	localparam int         ADR_W      = 5;

	// ****************************************
	// control fields and reset values
	// ****************************************
	localparam int         POWERDOWN_BIT    = 0;
	localparam int         DEPTH_SELECT_BIT = 1;
	localparam int         SYNC_EN_LSB      = 2;
	localparam logic [7:0] MASK_RST         = 8'hff;
	localparam logic [7:0] CTRL_RST         = 8'h00;

	// ****************************************
	// phase codes and timing
	// ****************************************
	localparam logic [1:0] PH_RED   = 2'h0;
	localparam logic [1:0] PH_GREEN = 2'h1;
	localparam logic [1:0] PH_BLUE  = 2'h2;
	localparam int         GAP_CYCLES = 4;

	typedef struct packed {
		logic [7:0] idx;
		logic [3:0] overlay_select_inputs;
		logic       sync_n;
		logic       blank_n;
	} plh_pix_t;

	typedef struct packed {
		logic [7:0] red;
		logic [7:0] green;
		logic [7:0] blue;
		logic [2:0] pedestal;
		logic       sync_n;
		logic       blank_n;
	} plh_dac_t;
endpackage

// ---- logic/plh_palette.sv ----
// palette look-up core with a classic Wishbone host port
//
// Decided for this implementation: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ns
module plh_palette #(
	parameter int GAP = plh_pkg::GAP_CYCLES
) (
	input  wire logic                       ref_clk_i,
	input  wire logic                       rstn_i,
	input  wire logic                       wb_cyc_i,
	input  wire logic                       wb_stb_i,
	input  wire logic                       wb_we_i,
	input  wire logic [plh_pkg::ADR_W-1:0]  wb_adr_i,
	input  wire logic [3:0]                 wb_sel_i,
	input  wire logic [31:0]                wb_dat_i,
	output logic      [31:0]                wb_dat_o,
	output logic                            wb_ack_o,
	input  wire plh_pkg::plh_pix_t          pix_i,
	input  wire logic                       depth_pin_i,
	input  wire logic                       over_threshold_i,
	output plh_pkg::plh_dac_t               dac_o,
	output logic                            dac_pd_o,
	output logic                            ram_pd_o,
	output logic                            sense_n_o
);
	import plh_pkg::*;

	localparam int GW = $clog2(GAP + 1);

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic [7:0]  ptr;
		logic [1:0]  phase;
		logic        rd_mode;
		logic [23:0] hold;
		logic [23:0] ohold;
		logic [7:0]  mask;
		logic [7:0]  ctrl;
		logic [GW-1:0] gap;
		logic        ack;
		logic [7:0]  dat;
		plh_pix_t    pin;
		logic [23:0] last;
		plh_dac_t    dac;
		logic        dac_pd;
		logic        ram_pd;
		logic        sense_n;
	} plh_state_t;

	plh_state_t s_r;
	plh_state_t s_nxt;

	logic [23:0] colour_ram [256];
	logic [23:0] overlay_ram [16];

	logic        cram_we;
	logic        oram_we;
	logic [7:0]  ram_addr;
	logic [23:0] ram_word;

	// ****************************************
	// helpers
	// ****************************************
	// store a host byte; six-bit data sits in 5..0 and lands left-aligned
	function automatic logic [7:0] byte_in(input logic [7:0] d, input logic d8);
		byte_in = d8 ? d : {d[5:0], 2'h0};
	endfunction

	function automatic logic [7:0] byte_out(input logic [7:0] b, input logic d8);
		byte_out = d8 ? b : {2'h0, b[7:2]};
	endfunction

	function automatic logic [7:0] pick(input logic [23:0] w, input logic [1:0] ph);
		case (ph)
			PH_RED:   pick = w[23:16];
			PH_GREEN: pick = w[15:8];
			default:  pick = w[7:0];
		endcase
	endfunction

	function automatic logic [23:0] place(input logic [23:0] w, input logic [1:0] ph,
			input logic [7:0] b);
		place = w;
		case (ph)
			PH_RED:   place[23:16] = b;
			PH_GREEN: place[15:8] = b;
			default:  place[7:0] = b;
		endcase
	endfunction

	// overlay slot zero is reserved and always reads as black
	function automatic logic [23:0] ovl_rd(input logic [3:0] a);
		ovl_rd = (a == 4'h0) ? 24'h0 : overlay_ram[a];
	endfunction

	// ****************************************
	// next state
	// ****************************************
	logic        req;
	logic        wr;
	logic        d8;
	logic        host_ram;
	logic [7:0]  wbyte;
	logic [23:0] word;
	logic [23:0] shown;

	always_comb begin
		s_nxt    = s_r;
		cram_we  = 1'b0;
		oram_we  = 1'b0;
		ram_addr = s_r.ptr;
		ram_word = s_r.hold;
		host_ram = 1'b0;
		d8       = depth_pin_i | s_r.ctrl[DEPTH_SELECT_BIT];
		// a new access waits until the gap of the previous one has run out
		req      = wb_cyc_i & wb_stb_i & ~s_r.ack & (s_r.gap == '0);
		wr       = wb_we_i & wb_sel_i[0];
		wbyte    = byte_in(wb_dat_i[7:0], d8);
		word     = 24'h0;
		shown    = 24'h0;

		s_nxt.ack = req;
		s_nxt.dat = 8'h0;
		if (req) begin
			s_nxt.gap = GW'(GAP);
		end else if (s_r.gap != '0) begin
			s_nxt.gap = s_r.gap - 1'b1;
		end

		if (req) begin
			case (wb_adr_i[4:2])
				RS_PTR_WR: begin
					if (wr) begin
						s_nxt.ptr     = wb_dat_i[7:0];
						s_nxt.phase   = PH_RED;
						s_nxt.rd_mode = 1'b0;
					end else begin
						s_nxt.dat = s_r.ptr;
					end
				end
				RS_PTR_RD: begin
					if (wr) begin
						// prefetch both tables, the next data access picks one
						s_nxt.hold    = colour_ram[wb_dat_i[7:0]];
						s_nxt.ohold   = ovl_rd(wb_dat_i[3:0]);
						s_nxt.ptr     = wb_dat_i[7:0] + 8'h1;
						s_nxt.phase   = PH_RED;
						s_nxt.rd_mode = 1'b1;
						host_ram      = 1'b1;
					end else begin
						s_nxt.dat = s_r.ptr;
					end
				end
				RS_COLOUR, RS_OVERLAY: begin
					host_ram = 1'b1;
					if (wr) begin
						s_nxt.hold = place(s_r.hold, s_r.phase, wbyte);
						if (s_r.phase == PH_BLUE) begin
							// whole word written at once after the blue byte
							ram_word = place(s_r.hold, PH_BLUE, wbyte);
							ram_addr = s_r.ptr;
							if (wb_adr_i[4:2] == RS_COLOUR) begin
								cram_we = 1'b1;
							end else begin
								// high pointer nibble plays no part for overlays
								ram_addr = {4'h0, s_r.ptr[3:0]};
								oram_we  = (s_r.ptr[3:0] != 4'h0);
							end
						end
					end else begin
						if (wb_adr_i[4:2] == RS_COLOUR) begin
							s_nxt.dat = byte_out(pick(s_r.hold, s_r.phase), d8);
						end else begin
							s_nxt.dat = byte_out(pick(s_r.ohold, s_r.phase), d8);
						end
						if (s_r.phase == PH_BLUE) begin
							// pointer already points past the entry being read
							s_nxt.hold  = colour_ram[s_r.ptr];
							s_nxt.ohold = ovl_rd(s_r.ptr[3:0]);
						end
					end
					if (s_r.phase == PH_BLUE) begin
						s_nxt.phase = PH_RED;
						s_nxt.ptr   = s_r.ptr + 8'h1;
					end else begin
						s_nxt.phase = s_r.phase + 2'h1;
					end
				end
				RS_MASK: begin
					if (wr) begin
						s_nxt.mask = wb_dat_i[7:0];
					end else begin
						s_nxt.dat = s_r.mask;
					end
				end
				RS_CTRL: begin
					if (wr) begin
						s_nxt.ctrl = wb_dat_i[7:0];
					end else begin
						s_nxt.dat = s_r.ctrl;
					end
				end
				RS_STATUS: begin
					s_nxt.dat = {3'h0, s_r.sense_n, d8, s_r.rd_mode, s_r.phase};
				end
				default: begin
					s_nxt.dat = 8'h0;
				end
			endcase
		end

		// pixel stage one: latch index, overlay select, sync and blank together
		s_nxt.pin     = pix_i;
		s_nxt.pin.idx = pix_i.idx & s_r.mask;

		// pixel stage two: look up, hold the old colour while the host owns the RAM
		if (s_r.pin.overlay_select_inputs == 4'h0) begin
			word = colour_ram[s_r.pin.idx];
		end else begin
			word = ovl_rd(s_r.pin.overlay_select_inputs);
		end
		if (!d8) begin
			word = word & 24'hfcfcfc;
		end
		if (!host_ram) begin
			s_nxt.last = word;
		end
		shown = host_ram ? s_r.last : word;
		if (!s_r.pin.blank_n) begin
			shown = 24'h0;
		end
		s_nxt.dac.red      = shown[23:16];
		s_nxt.dac.green    = shown[15:8];
		s_nxt.dac.blue     = shown[7:0];
		// pedestal only on enabled channels and only while sync is high
		s_nxt.dac.pedestal = s_r.ctrl[SYNC_EN_LSB +: 3] & {3{s_r.pin.sync_n}};
		s_nxt.dac.sync_n   = s_r.pin.sync_n;
		s_nxt.dac.blank_n  = s_r.pin.blank_n;

		// ram wakes for the cycle of each colour or overlay access and read-pointer write, then sleeps again
		s_nxt.dac_pd  = s_r.ctrl[POWERDOWN_BIT];
		s_nxt.ram_pd  = s_r.ctrl[POWERDOWN_BIT] & ~host_ram;
		s_nxt.sense_n = ~over_threshold_i;
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s_r      <= '0;
			s_r.mask <= MASK_RST;
			s_r.ctrl <= CTRL_RST;
			s_r.sense_n <= 1'b1;
			s_r.dac.sync_n  <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// tables keep their contents in powerdown and are never cleared
	always_ff @(posedge ref_clk_i) begin
		if (cram_we) begin
			colour_ram[ram_addr] <= ram_word;
		end
		if (oram_we) begin
			overlay_ram[ram_addr[3:0]] <= ram_word;
		end
	end

	assign wb_dat_o  = {24'h0, s_r.dat};
	assign wb_ack_o  = s_r.ack;
	assign dac_o     = s_r.dac;
	assign dac_pd_o  = s_r.dac_pd;
	assign ram_pd_o  = s_r.ram_pd;
	assign sense_n_o = s_r.sense_n;
endmodule

// ---- verif/plh_palette_props.sv ----
// concurrent checks on the palette look-up block ports
`timescale 1ns/1ns
module plh_palette_props #(
	parameter int GAP = 4
) (
	input wire logic              ref_clk_i,
	input wire logic              rstn_i,
	input wire logic              wb_cyc_i,
	input wire logic              wb_stb_i,
	input wire logic              wb_we_i,
	input wire logic [4:0]        wb_adr_i,
	input wire logic [31:0]       wb_dat_o,
	input wire logic              wb_ack_o,
	input wire plh_pkg::plh_pix_t pix_i,
	input wire logic              over_threshold_i,
	input wire plh_pkg::plh_dac_t dac_o,
	input wire logic              dac_pd_o,
	input wire logic              ram_pd_o,
	input wire logic              sense_n_o
);
	import plh_pkg::*;
	logic [1:0] up_r;
	logic       ram_acc;
	// pixel history is only meaningful three edges after reset
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) up_r <= 2'h0;
		else if (up_r != 2'h3) up_r <= up_r + 2'h1;
	end
	assign ram_acc = wb_adr_i[4:2] == RS_COLOUR || wb_adr_i[4:2] == RS_OVERLAY;
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rstn_i);
	// repetition count fixed at 3, one below the four idle cycles of the default gap of 4
	chk_ack_spacing: assert property (wb_ack_o |=> !wb_ack_o [*3])
		else $error("acks closer than the access gap");
	chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without a request");
	chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data outside ack");
	chk_dat_upper: assert property (wb_dat_o[31:8] == 24'h0)
		else $error("upper read lines not zero");
	chk_ram_wake: assert property (wb_ack_o && ram_acc |-> !ram_pd_o)
		else $error("ram stayed off during a host access");
	chk_pd_cause: assert property ($changed(dac_pd_o) |->
		$past(wb_ack_o && wb_we_i && wb_adr_i[4:2] == RS_CTRL))
		else $error("converter powerdown changed without a control write");
	chk_sense_follow: assert property ($past(rstn_i) |->
		sense_n_o == !$past(over_threshold_i))
		else $error("monitor detect does not follow comparator");
	chk_sync_align: assert property (up_r == 2'h3 |-> dac_o.sync_n == $past(pix_i.sync_n, 2)
		&& dac_o.blank_n == $past(pix_i.blank_n, 2))
		else $error("sync or blank misaligned with colour");
	chk_blank_zero: assert property (up_r == 2'h3 && !$past(pix_i.blank_n, 2) |->
		{dac_o.red, dac_o.green, dac_o.blue} == 24'h0)
		else $error("colour shown while blanked");
	cover property (wb_ack_o && wb_we_i && ram_acc);
	cover property (wb_ack_o && !wb_we_i && ram_acc);
	cover property (dac_pd_o && wb_ack_o && ram_acc);
	cover property (!dac_o.blank_n);
endmodule
bind plh_palette plh_palette_props #(.GAP(GAP)) i_props (.ref_clk_i(ref_clk_i),
	.rstn_i(rstn_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pix_i(pix_i),
	.over_threshold_i(over_threshold_i), .dac_o(dac_o), .dac_pd_o(dac_pd_o),
	.ram_pd_o(ram_pd_o), .sense_n_o(sense_n_o));

// ---- verif/plh_host_model.sv ----
// graphics controller model: classic Wishbone master into the palette block
`timescale 1ns/1ns
module plh_host_model (
	input  wire logic        ref_clk_i,
	input  wire logic        ack_i,
	input  wire logic [31:0] dat_i,
	output logic             cyc_o,
	output logic             stb_o,
	output logic             we_o,
	output logic [4:0]       adr_o,
	output logic [3:0]       sel_o,
	output logic [31:0]      dat_o
);
	import plh_pkg::*;
	initial begin
		{cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
	end
	// holds the request until ack; the block itself spaces takings by the gap
	task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge ref_clk_i);
		{cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} <= {2'b11, w, a, 4'h1, 24'h0, d};
		do @(posedge ref_clk_i); while (ack_i !== 1'b1);
		q = dat_i[7:0];
		{cyc_o, stb_o} <= 2'b00;
		// released address and data lines must not keep showing the old value
		adr_o <= ~a;
		dat_o <= ~dat_o;
	endtask
endmodule

// ---- verif/testbench.sv ----
// self-checking bench for the palette look-up block
`timescale 1ns/1ns
module testbench;
	import plh_pkg::*;
	logic        ref_clk_i = 1'b0, rstn_i = 1'b0, depth = 1'b1, ovr = 1'b0, pev = 1'b0;
	logic        cyc, stb, we, ack;
	logic [4:0]  adr;
	logic [3:0]  sel;
	logic [31:0] wdat, rdat, seed;
	logic [7:0]  c [6];
	logic [7:0]  rq [$];
	logic [31:0] pq [$];
	plh_pix_t    pix = '{8'h0, 4'h0, 1'b1, 1'b1};
	plh_dac_t    dac;
	int          fail_count = 0, checks = 0;
	always #5 ref_clk_i = ~ref_clk_i; // pixel clock never stops
	always @(posedge ref_clk_i) ovr <= ~ovr;
	plh_host_model i_host (.ref_clk_i(ref_clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc),
		.stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));
	plh_palette i_dut (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .pix_i(pix), .depth_pin_i(depth), .over_threshold_i(ovr),
		.dac_o(dac), .dac_pd_o(), .ram_pd_o(), .sense_n_o());
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict();
		$display("checks=%0d fail_count=%0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		logic [7:0] q;
		i_host.bus(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [4:0] a, input logic [7:0] e);
		logic [7:0] q;
		rq.push_back(e);
		i_host.bus(1'b0, a, 8'h0, q);
	endtask
	task automatic px(input plh_pix_t p, input logic [26:0] e);
		@(posedge ref_clk_i) pix <= p;
		repeat (3) @(posedge ref_clk_i);
		pq.push_back({5'h0, e});
		pev <= 1'b1;
		@(posedge ref_clk_i) pev <= 1'b0;
	endtask
	always @(posedge ref_clk_i) begin
		if (ack && !we) check(rdat, {24'h0, rq.pop_front()});
		if (pev) check({5'h0, dac.red, dac.green, dac.blue, dac.pedestal}, pq.pop_front());
	end
	initial begin
		#300000;
		fail_count++;
		print_verdict();
	end
	initial begin
		seed = 32'hf33e;
		repeat (5) @(posedge ref_clk_i);
		rstn_i <= 1'b1;
		rd(5'h08, MASK_RST);
		rd(5'h18, CTRL_RST);
		wr(5'h10, 8'h5a);
		rd(5'h10, 8'h00);
		wr(5'h18, 8'h14);
		foreach (c[i]) c[i] = $random(seed);
		wr(5'h00, 8'hfe);
		foreach (c[i]) wr(5'h04, c[i]);
		rd(5'h00, 8'h00);
		wr(5'h0c, 8'hfe);
		rd(5'h04, c[0]);
		rd(5'h00, 8'hff);
		for (int i = 1; i < 6; i++) rd(5'h04, c[i]);
		wr(5'h08, 8'hfe);
		px('{8'hff, 4'h0, 1'b1, 1'b1}, {c[0], c[1], c[2], 3'h5});
		wr(5'h08, 8'hff);
		px('{8'hff, 4'h0, 1'b0, 1'b1}, {c[3], c[4], c[5], 3'h0});
		wr(5'h00, 8'hf3);
		for (int i = 5; i > 2; i--) wr(5'h14, c[i]);
		px('{8'h00, 4'h3, 1'b1, 1'b1}, {c[5], c[4], c[3], 3'h5});
		px('{8'h00, 4'h3, 1'b1, 1'b0}, {24'h0, 3'h5});
		depth <= 1'b0;
		wr(5'h18, 8'h11);
		wr(5'h00, 8'h20);
		wr(5'h04, 8'hff);
		wr(5'h04, 8'h81);
		wr(5'h04, 8'h3c);
		wr(5'h0c, 8'h20);
		rd(5'h04, 8'h3f);
		rd(5'h04, 8'h01);
		rd(5'h04, 8'h3c);
		px('{8'h20, 4'h0, 1'b1, 1'b1}, {8'hfc, 8'h04, 8'hf0, 3'h4});
		repeat (4) @(posedge ref_clk_i);
		print_verdict();
	end
endmodule
